//--- dv/ext_clk_src.sv
// external count clock source feeding the timer's clock pin
`timescale 1ns/1ps
`default_nettype none

module ext_clk_src (
  input wire logic aclk, // pacing clock
  output logic pin // external count clock, idles low
);
  initial pin = 1'b0;

  // ----
  // bursts of rising edges
  // ----
  // half sets the pace: small is prompt, large is slow
  task automatic burst(input int n, input int half);
    repeat (n)
    begin
      pin <= 1'b1;
      repeat (half) @(posedge aclk);
      pin <= 1'b0;
      repeat (half) @(posedge aclk);
    end
  endtask
endmodule // ext_clk_src

`default_nettype wire

//--- dv/sixteen_bit_timer_counter_test.sv
// testbench: timer16 through its register bus and count pin
`timescale 1ns/1ps
`default_nettype none

module sixteen_bit_timer_counter_test;
  logic aclk, aresetn, pin, sleep, ovf;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, d;
  logic [3:0] wstrb;
  logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic [1:0] bresp, rresp, r, br;
  int fail_count, n_checks;

  ext_clk_src ext_u (.aclk(aclk), .pin(pin));
  timer16 dut_u (.aclk(aclk), .aresetn(aresetn), .ext_clk_pin(pin), .cpu_sleep(sleep), .overflow_flag(ovf),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready));

  // ----
  // checking and bus tasks
  // ----
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("wrong value at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask

  task automatic summarize();
    if (fail_count == 0 && n_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    logic done;
    done = 1'b0;
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    while (!done)
    begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid && bready)
      begin
        br = bresp;
        bready <= 1'b0;
        done = 1'b1;
      end
      else if (bvalid) bready <= 1'b1;
    end
    @(posedge aclk);
  endtask

  task automatic rd(input logic [7:0] a);
    logic done;
    done = 1'b0;
    araddr <= a;
    arvalid <= 1'b1;
    while (!done)
    begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid && rready)
      begin
        d = rdata;
        r = rresp;
        rready <= 1'b0;
        done = 1'b1;
      end
      else if (rvalid) rready <= 1'b1;
    end
    @(posedge aclk);
  endtask

  // count pin edges under control word c, then stop and read the low byte
  task automatic pulses(input logic [31:0] c, input int n, input int half);
    wr(tmr16_pkg::OFF_CTRL, c);
    ext_u.burst(n, half);
    repeat (8) @(posedge aclk);
    wr(tmr16_pkg::OFF_CTRL, 32'h0000_0000);
    rd(tmr16_pkg::OFF_LOW);
  endtask

  // ----
  // clock, watchdog, tests
  // ----
  initial
  begin
    aclk = 1'b0;
    forever #50 aclk = ~aclk;
  end

  initial
  begin
    #2000000;
    fail_count++;
    summarize();
  end

  initial
  begin
    aresetn = 1'b0;
    sleep = 1'b0;
    awaddr = 8'h00;
    araddr = 8'h00;
    wdata = 32'h0000_0000;
    wstrb = 4'hF;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    rd(tmr16_pkg::OFF_LOW);
    chk(d, 32'h0000_0000);
    rd(8'h10);
    chk(r, tmr16_pkg::RESP_SLVERR);
    chk(d, 32'h0000_0000);
    // internal clock: 25 edges see run between the two control writes
    wr(tmr16_pkg::OFF_CTRL, 32'h0000_0001);
    repeat (20) @(posedge aclk);
    wr(tmr16_pkg::OFF_CTRL, 32'h0000_0000);
    chk(br, tmr16_pkg::RESP_OKAY);
    wr(8'h10, 32'h0000_00FF);
    chk(br, tmr16_pkg::RESP_SLVERR);
    rd(tmr16_pkg::OFF_LOW);
    chk(d, 32'h0000_0019);
    for (int ps = 0; ps < 4; ps++)
    begin
      wr(tmr16_pkg::OFF_LOW, 32'h0000_0000);
      pulses(32'h0000_0021 | (ps << 3), 16, 3 + ps);
      chk(d, 32'h0000_0010 >> ps);
    end
    wr(tmr16_pkg::OFF_LOW, 32'h0000_0000);
    wr(tmr16_pkg::OFF_CTRL, 32'h0000_0039);
    ext_u.burst(4, 3);
    wr(tmr16_pkg::OFF_HIGH, 32'h0000_0000);
    ext_u.burst(4, 3);
    repeat (8) @(posedge aclk);
    rd(tmr16_pkg::OFF_LOW);
    chk(d, 32'h0000_0001);
    ext_u.burst(4, 3);
    wr(tmr16_pkg::OFF_LOW, 32'h0000_0000);
    pulses(32'h0000_0039, 4, 3);
    chk(d, 32'h0000_0000);
    sleep <= 1'b1;
    wr(tmr16_pkg::OFF_LOW, 32'h0000_0000);
    pulses(32'h0000_0025, 5, 3);
    chk(d, 32'h0000_0005);
    wr(tmr16_pkg::OFF_LOW, 32'h0000_0000);
    pulses(32'h0000_0021, 5, 3);
    chk(d, 32'h0000_0000);
    sleep <= 1'b0;
    wr(tmr16_pkg::OFF_HIGH, 32'h0000_00FF);
    wr(tmr16_pkg::OFF_LOW, 32'h0000_00FF);
    pulses(32'h0000_0021, 1, 6);
    chk(d, 32'h0000_0000);
    chk(ovf, 32'h0000_0001);
    rd(tmr16_pkg::OFF_HIGH);
    chk(d, 32'h0000_0000);
    wr(tmr16_pkg::OFF_STAT, 32'h0000_0001);
    rd(tmr16_pkg::OFF_STAT);
    chk(d, 32'h0000_0000);
    wr(tmr16_pkg::OFF_CTRL, 32'h0000_0002);
    wr(tmr16_pkg::OFF_HIGH, 32'h0000_00AB);
    wr(tmr16_pkg::OFF_CTRL, 32'h0000_0000);
    rd(tmr16_pkg::OFF_HIGH);
    chk(d, 32'h0000_0000);
    wr(tmr16_pkg::OFF_CTRL, 32'h0000_0002);
    rd(tmr16_pkg::OFF_HIGH);
    chk(d, 32'h0000_00AB);
    wr(tmr16_pkg::OFF_LOW, 32'h0000_00CD);
    wr(tmr16_pkg::OFF_HIGH, 32'h0000_0055);
    rd(tmr16_pkg::OFF_LOW);
    chk(d, 32'h0000_00CD);
    rd(tmr16_pkg::OFF_HIGH);
    chk(d, 32'h0000_00AB);
    wr(tmr16_pkg::OFF_CTRL, 32'h0000_0000);
    rd(tmr16_pkg::OFF_HIGH);
    chk(d, 32'h0000_00AB);
    summarize();
  end
endmodule // sixteen_bit_timer_counter_test

`default_nettype wire

//--- hdl/timer16.sv
// top: 16-bit timer/counter with prescaler, async mode and atomic wide access
//
// Chosen here: the AXI4-Lite register port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none

// Contract
// - prescaler divides the selected clock by 1, 2, 4 or 8 per prescale_select
// - prescale counter has no address; software cannot read or write it
// - low byte write clears prescale counter; high byte write leaves it alone
// - sync_dis set: external input skips the extra sync stage, counts one stage earlier
// - async external mode keeps counting in sleep; overflow flag can wake
// - sync/async switch may drop or add one increment
// - reads of either byte return a valid value while running async
// - wide_access_enable turns on atomic 16-bit read and write
// - wide mode: high byte address reaches the buffer, not the live byte
// - wide mode: low byte read copies live high byte into buffer
// - wide mode: high byte read returns buffer contents
// - wide mode: low byte write loads buffer and new low byte together
module timer16 (
  input wire logic aclk, // system clock
  input wire logic aresetn, // synchronous reset, active low
  input wire logic ext_clk_pin, // external count clock pin
  input wire logic cpu_sleep, // processor in sleep
  output logic overflow_flag, // sticky overflow, wake source
  input wire logic [tmr16_pkg::ADDR_W-1:0] s_axi_awaddr, // write address
  input wire logic s_axi_awvalid, // write address valid
  output logic s_axi_awready, // write address ready
  input wire logic [tmr16_pkg::DATA_W-1:0] s_axi_wdata, // write data
  input wire logic [3:0] s_axi_wstrb, // write byte strobes
  input wire logic s_axi_wvalid, // write data valid
  output logic s_axi_wready, // write data ready
  output logic [1:0] s_axi_bresp, // write response
  output logic s_axi_bvalid, // write response valid
  input wire logic s_axi_bready, // write response ready
  input wire logic [tmr16_pkg::ADDR_W-1:0] s_axi_araddr, // read address
  input wire logic s_axi_arvalid, // read address valid
  output logic s_axi_arready, // read address ready
  output logic [tmr16_pkg::DATA_W-1:0] s_axi_rdata, // read data
  output logic [1:0] s_axi_rresp, // read response
  output logic s_axi_rvalid, // read data valid
  input wire logic s_axi_rready // read data ready
);

  tmr16_pkg::state_t st;
  tmr16_pkg::state_t next_st;

  // ----------------------------------------------------------------
  // internal decode
  // ----------------------------------------------------------------
  logic ext_edge;
  logic tick_src;
  logic may_count;
  logic [2:0] pre_lim;
  logic inc;
  logic do_write;
  logic wr_low;
  logic wr_high;
  logic wr_ctrl;
  logic wr_stat;
  logic ar_take;
  logic rd_low;
  logic rd_high;
  logic [15:0] count_inc;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb
  begin
    next_st = st;
    // pin synchroniser; stage 0 feeds only stage 1
    next_st.ext_sy = {st.ext_sy[2:0], ext_clk_pin};
    // async mode takes the edge one stage earlier than sync mode
    if (st.ctrl.sync_dis)
    begin
      ext_edge = st.ext_sy[1] & ~st.ext_sy[2];
    end
    else
    begin
      ext_edge = st.ext_sy[2] & ~st.ext_sy[3];
    end
    tick_src = st.ctrl.ext_sel ? ext_edge : 1'b1;
    // only async external counting survives sleep
    may_count = st.ctrl.run & (~cpu_sleep | (st.ctrl.sync_dis & st.ctrl.ext_sel));
    pre_lim = 3'((4'h1 << st.ctrl.prescale_select) - 4'h1);
    inc = may_count & tick_src & (st.pcnt >= pre_lim);
    count_inc = st.count + tmr16_pkg::COUNT_ONE;

    // prescale counter steps on every source tick while may_count is set
    if (may_count & tick_src)
    begin
      next_st.pcnt = (st.pcnt >= pre_lim) ? tmr16_pkg::PRE_ZERO : 3'(st.pcnt + 3'h1);
    end
    if (inc)
    begin
      next_st.count = count_inc;
      if (st.count == tmr16_pkg::COUNT_ALL_ONES)
      begin
        next_st.ovf = 1'b1;
      end
    end

    // write channel
    if (s_axi_awvalid & st.awready)
    begin
      next_st.aw_have = 1'b1;
      next_st.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid & st.wready)
    begin
      next_st.w_have = 1'b1;
      next_st.w_data = s_axi_wdata;
      next_st.w_strb = s_axi_wstrb;
    end
    do_write = st.aw_have & st.w_have & ~st.bvalid;
    wr_ctrl = do_write & st.w_strb[0] & (st.aw_addr == tmr16_pkg::OFF_CTRL);
    wr_low = do_write & st.w_strb[0] & (st.aw_addr == tmr16_pkg::OFF_LOW);
    wr_high = do_write & st.w_strb[0] & (st.aw_addr == tmr16_pkg::OFF_HIGH);
    wr_stat = do_write & st.w_strb[0] & (st.aw_addr == tmr16_pkg::OFF_STAT);
    if (do_write)
    begin
      next_st.aw_have = 1'b0;
      next_st.w_have = 1'b0;
      next_st.bvalid = 1'b1;
      if ((st.aw_addr == tmr16_pkg::OFF_CTRL) || (st.aw_addr == tmr16_pkg::OFF_LOW) ||
          (st.aw_addr == tmr16_pkg::OFF_HIGH) || (st.aw_addr == tmr16_pkg::OFF_STAT))
      begin
        next_st.bresp = tmr16_pkg::RESP_OKAY;
      end
      else
      begin
        next_st.bresp = tmr16_pkg::RESP_SLVERR;
      end
    end
    else if (st.bvalid & s_axi_bready)
    begin
      next_st.bvalid = 1'b0;
    end
    if (wr_ctrl)
    begin
      next_st.ctrl = tmr16_pkg::ctrl_t'(st.w_data[tmr16_pkg::CTRL_W-1:0]);
    end
    // a count write replaces the bytes it loads; the other byte keeps a coincident increment
    if (wr_low)
    begin
      next_st.pcnt = tmr16_pkg::PRE_ZERO;
      if (st.ctrl.wide_access_enable)
      begin
        next_st.count = {st.hbuf, st.w_data[7:0]};
      end
      else
      begin
        next_st.count[7:0] = st.w_data[7:0];
      end
    end
    if (wr_high)
    begin
      if (st.ctrl.wide_access_enable)
      begin
        next_st.hbuf = st.w_data[7:0];
      end
      else
      begin
        next_st.count[15:8] = st.w_data[7:0];
      end
    end
    // write-one-to-clear; a new overflow in the same cycle wins
    if (wr_stat && st.w_data[tmr16_pkg::STAT_OVF_BIT] &&
        !(inc && st.count == tmr16_pkg::COUNT_ALL_ONES))
    begin
      next_st.ovf = 1'b0;
    end

    // read channel; the prescale counter has no address
    ar_take = s_axi_arvalid & st.arready;
    rd_low = ar_take & (s_axi_araddr == tmr16_pkg::OFF_LOW);
    rd_high = ar_take & (s_axi_araddr == tmr16_pkg::OFF_HIGH);
    if (ar_take)
    begin
      next_st.rvalid = 1'b1;
      next_st.rresp = tmr16_pkg::RESP_OKAY;
      next_st.rdata = tmr16_pkg::WORD_ZERO;
      // register copy of count is always coherent in this clock domain
      unique case (s_axi_araddr)
        tmr16_pkg::OFF_CTRL: next_st.rdata[tmr16_pkg::CTRL_W-1:0] = st.ctrl;
        tmr16_pkg::OFF_LOW: next_st.rdata[7:0] = st.count[7:0];
        tmr16_pkg::OFF_HIGH: next_st.rdata[7:0] = st.ctrl.wide_access_enable ? st.hbuf : st.count[15:8];
        tmr16_pkg::OFF_STAT: next_st.rdata[tmr16_pkg::STAT_OVF_BIT] = st.ovf;
        default: next_st.rresp = tmr16_pkg::RESP_SLVERR;
      endcase
    end
    else if (st.rvalid & s_axi_rready)
    begin
      next_st.rvalid = 1'b0;
    end
    // snapshot, unless a buffer write lands in the same cycle
    if (rd_low && st.ctrl.wide_access_enable && !(wr_high))
    begin
      next_st.hbuf = st.count[15:8];
    end

    next_st.awready = ~next_st.aw_have & ~next_st.bvalid;
    next_st.wready = ~next_st.w_have & ~next_st.bvalid;
    next_st.arready = ~next_st.rvalid;
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      st <= '{default: '0};
      st.ctrl <= tmr16_pkg::CTRL_RESET;
    end
    else
    begin
      st <= next_st;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign overflow_flag = st.ovf;
  assign s_axi_awready = st.awready;
  assign s_axi_wready = st.wready;
  assign s_axi_bresp = st.bresp;
  assign s_axi_bvalid = st.bvalid;
  assign s_axi_arready = st.arready;
  assign s_axi_rdata = st.rdata;
  assign s_axi_rresp = st.rresp;
  assign s_axi_rvalid = st.rvalid;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  a_low_clr_pre: assert property (@(posedge aclk) disable iff (!aresetn)
    wr_low |=> st.pcnt == tmr16_pkg::PRE_ZERO)
    else $error("low byte write did not clear prescaler");

  a_high_keep_pre: assert property (@(posedge aclk) disable iff (!aresetn)
    (wr_high && !(may_count && tick_src)) |=> $stable(st.pcnt))
    else $error("high byte write disturbed prescaler");

  a_pre_ratio: assert property (@(posedge aclk) disable iff (!aresetn)
    inc |=> st.pcnt == tmr16_pkg::PRE_ZERO)
    else $error("prescaler not restarted after increment");

  a_ovf_set: assert property (@(posedge aclk) disable iff (!aresetn)
    (inc && st.count == tmr16_pkg::COUNT_ALL_ONES && !wr_low && !wr_high) |=>
      (overflow_flag && st.count == '0))
    else $error("wrap did not set overflow");

  a_wide_snap: assert property (@(posedge aclk) disable iff (!aresetn)
    (rd_low && st.ctrl.wide_access_enable && !wr_high) |=> st.hbuf == $past(st.count[15:8]))
    else $error("low read did not snapshot high byte");

  a_wide_rdhi: assert property (@(posedge aclk) disable iff (!aresetn)
    (rd_high && st.ctrl.wide_access_enable) |=> s_axi_rvalid && s_axi_rdata[7:0] == $past(st.hbuf))
    else $error("wide high read not from buffer");

  a_wide_wrlo: assert property (@(posedge aclk) disable iff (!aresetn)
    (wr_low && st.ctrl.wide_access_enable) |=> st.count == {$past(st.hbuf), $past(st.w_data[7:0])})
    else $error("wide low write not atomic");

  a_wide_hold_live: assert property (@(posedge aclk) disable iff (!aresetn)
    (wr_high && st.ctrl.wide_access_enable && !inc && !wr_low) |=> $stable(st.count))
    else $error("wide high write reached live byte");

  a_sleep_hold: assert property (@(posedge aclk) disable iff (!aresetn)
    (cpu_sleep && !(st.ctrl.sync_dis && st.ctrl.ext_sel) && !wr_low && !wr_high) |=> $stable(st.count))
    else $error("counted in sleep outside async mode");

  a_rd_hold: assert property (@(posedge aclk) disable iff (!aresetn)
    (s_axi_rvalid && !s_axi_rready) |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped before handshake");

  a_wr_hold: assert property (@(posedge aclk) disable iff (!aresetn)
    (s_axi_bvalid && !s_axi_bready) |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped before handshake");

  a_wr_answer: assert property (@(posedge aclk) disable iff (!aresetn)
    do_write |=> s_axi_bvalid)
    else $error("write not answered");

  a_rd_answer: assert property (@(posedge aclk) disable iff (!aresetn)
    ar_take |=> s_axi_rvalid)
    else $error("read not answered");

  a_busy_no_aw: assert property (@(posedge aclk) disable iff (!aresetn)
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write channels open while response pending");

  a_busy_no_ar: assert property (@(posedge aclk) disable iff (!aresetn)
    s_axi_rvalid |-> !s_axi_arready)
    else $error("read address open while data pending");

  a_ovf_sticky: assert property (@(posedge aclk) disable iff (!aresetn)
    (st.ovf && !wr_stat) |=> overflow_flag)
    else $error("overflow flag dropped without clear");

  a_ovf_clear: assert property (@(posedge aclk) disable iff (!aresetn)
    (wr_stat && st.w_data[tmr16_pkg::STAT_OVF_BIT] && !inc) |=> !overflow_flag)
    else $error("overflow flag not cleared");

  a_edge_only: assert property (@(posedge aclk) disable iff (!aresetn)
    (st.ctrl.ext_sel && !ext_edge && !wr_low && !wr_high) |=> $stable(st.count))
    else $error("external mode counted without pin edge");

  a_sleep_count: assert property (@(posedge aclk) disable iff (!aresetn)
    (cpu_sleep && st.ctrl.run && st.ctrl.sync_dis && st.ctrl.ext_sel && ext_edge &&
     pre_lim == tmr16_pkg::PRE_ZERO && !wr_low && !wr_high) |=>
      st.count == $past(st.count) + tmr16_pkg::COUNT_ONE)
    else $error("async count stopped in sleep");

  a_pre_step: assert property (@(posedge aclk) disable iff (!aresetn)
    (may_count && tick_src && st.pcnt < pre_lim && !wr_low) |=> st.pcnt == $past(st.pcnt) + 3'h1)
    else $error("prescaler missed a source tick");

  a_ctrl_load: assert property (@(posedge aclk) disable iff (!aresetn)
    wr_ctrl |=> st.ctrl == $past(st.w_data[tmr16_pkg::CTRL_W-1:0]))
    else $error("control write not taken");

  a_narrow_rdhi: assert property (@(posedge aclk) disable iff (!aresetn)
    (rd_high && !st.ctrl.wide_access_enable) |=> s_axi_rdata[7:0] == $past(st.count[15:8]))
    else $error("narrow high read not from live byte");

  a_rd_low: assert property (@(posedge aclk) disable iff (!aresetn)
    rd_low |=> s_axi_rdata[7:0] == $past(st.count[7:0]))
    else $error("low read not from live byte");

  a_unmapped_rd: assert property (@(posedge aclk) disable iff (!aresetn)
    (ar_take && !rd_low && !rd_high && s_axi_araddr != tmr16_pkg::OFF_CTRL &&
     s_axi_araddr != tmr16_pkg::OFF_STAT) |=>
      (s_axi_rresp == tmr16_pkg::RESP_SLVERR && s_axi_rdata == tmr16_pkg::WORD_ZERO))
    else $error("unmapped read not refused");

endmodule // timer16

`default_nettype wire

//--- hdl/tmr16_pkg.sv
// package: constants and types for the 16-bit timer/counter
package tmr16_pkg;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;

  // byte addresses of the register words
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_LOW = 8'h04;
  localparam logic [7:0] OFF_HIGH = 8'h08;
  localparam logic [7:0] OFF_STAT = 8'h0C;

  // status word bit position of the overflow flag
  localparam int STAT_OVF_BIT = 0;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  localparam logic [2:0] PRE_ZERO = 3'h0;
  localparam logic [15:0] COUNT_ALL_ONES = 16'hFFFF;
  localparam logic [15:0] COUNT_ONE = 16'h0001;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic [31:0] WORD_ZERO = 32'h0000_0000;

  // timer control register, low bits upward: run, wide, sync_dis, prescale_select, ext_sel
  typedef struct packed {
    logic ext_sel;
    logic [1:0] prescale_select;
    logic sync_dis;
    logic wide_access_enable;
    logic run;
  } ctrl_t;

  localparam int CTRL_W = 6;
  localparam ctrl_t CTRL_RESET = '{default: 1'b0};

  typedef struct packed {
    ctrl_t ctrl;
    logic [15:0] count;
    logic [7:0] hbuf;
    logic [2:0] pcnt;
    logic ovf;
    logic [3:0] ext_sy;
    logic aw_have;
    logic [ADDR_W-1:0] aw_addr;
    logic w_have;
    logic [DATA_W-1:0] w_data;
    logic [3:0] w_strb;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [DATA_W-1:0] rdata;
    logic [1:0] rresp;
  } state_t;

endpackage
